// ==== design/dce_pkg.sv ====
// Package: shared types and constants for the decrement/complement executor
package dce_pkg;

  // ==========================================================
  // Widths and encodings
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_MAX = 7'h7f;
  localparam logic [5:0] OPC_INVERT = 6'h09;
  localparam logic [5:0] OPC_DEC = 6'h03;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;
  localparam logic [7:0] DEC_STEP = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZFLAG_RESET = 1'b0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    DCE_OP_NONE,
    DCE_OP_INVERT,
    DCE_OP_DEC,
    DCE_OP_DEC_SKIP
  } dce_op_t;

  typedef struct packed {
    logic [13:0] word;
    logic valid;
  } dce_instr_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic we;
  } dce_wr_t;

endpackage : dce_pkg

// ==== design/dce_phase_gen.sv ====
// Four-phase sequencer for one instruction cycle
`timescale 1ns/1ps
module dce_phase_gen
  import dce_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  output logic [3:0] phase_onehot
);

  // ==========================================================
  // Rotating one-hot phase
  logic [3:0] phase_ff;
  logic [3:0] nxt_phase;

  assign nxt_phase = {phase_ff[2:0], phase_ff[3]};
  assign phase_onehot = phase_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= 4'h1;
    end else if (clk_en) begin
      phase_ff <= nxt_phase;
    end
  end

endmodule : dce_phase_gen

// ==== design/dce_exec.sv ====
// Execution unit for invert, decrement and decrement-skip-on-zero
`timescale 1ns/1ps

// How it works
// RULE_01: Decrement takes a 7-bit register address and one destination bit.
// RULE_02: Decrement subtracts one and sends the result to the chosen place.
// RULE_03: Destination bit 0 writes the accumulator; register left alone.
// RULE_04: Phases: decode, read register, process, write destination.
// RULE_05: Decrement-skip is one cycle, or two with an idle second cycle.
// RULE_06: Zero result skips the next instruction in the program counter.
// RULE_07: Nonzero result runs next instruction; zero replaces it with idle.
// RULE_08: Invert flips all bits; destination 0 accumulator, 1 register.
// RULE_09: Destination bit 1 writes the decrement-skip result to register.
// RULE_10: Zero flag follows invert and decrement; decrement-skip leaves it.
module dce_exec
  import dce_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire dce_instr_t instr_in,
  input wire logic [7:0] rd_data,
  output logic [6:0] rd_addr,
  output logic rd_en,
  output dce_wr_t reg_wr,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic skip_next,
  output logic busy,
  output logic [3:0] phase
);

  // ==========================================================
  // Phase sequencer
  logic [3:0] ph;

  dce_phase_gen u_phase (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .phase_onehot(ph)
  );

  wire ph_one = ph[0];
  wire ph_two = ph[1];
  wire ph_three = ph[2];
  wire ph_four = ph[3];

  // ==========================================================
  // Decode, done in phase one
  wire [5:0] opc = instr_in.word[OPC_MSB:OPC_LSB];
  wire dest_in = instr_in.word[DEST_BIT];
  wire [6:0] addr_in = instr_in.word[6:0];
  dce_op_t dec_op;

  always_comb begin
    case (opc)
      OPC_INVERT: dec_op = DCE_OP_INVERT;
      OPC_DEC: dec_op = DCE_OP_DEC;
      OPC_DEC_SKIP: dec_op = DCE_OP_DEC_SKIP;
      default: dec_op = DCE_OP_NONE;
    endcase
  end

  dce_op_t op_ff;
  logic dest_ff;
  logic [6:0] addr_ff;
  logic [7:0] opnd_ff;
  logic [7:0] res_ff;
  logic idle_ff;
  logic [7:0] acc_ff;
  logic zf_ff;
  logic skip_ff;
  logic busy_ff;
  logic rd_en_ff;
  logic [6:0] rd_addr_ff;
  dce_wr_t wr_ff;
  logic [3:0] phase_ff;

  // Idle second cycle swallows the fetched word: decode nothing
  wire take = ph_one && instr_in.valid && !idle_ff; // RULE_05
  dce_op_t nxt_op;
  assign nxt_op = take ? dec_op : DCE_OP_NONE;

  // ==========================================================
  // Processing
  wire [7:0] dec_res = opnd_ff - DEC_STEP; // RULE_02
  wire [7:0] inv_res = ~opnd_ff; // RULE_08
  logic [7:0] nxt_res;

  always_comb begin
    case (op_ff)
      DCE_OP_INVERT: nxt_res = inv_res;
      DCE_OP_DEC: nxt_res = dec_res;
      DCE_OP_DEC_SKIP: nxt_res = dec_res;
      default: nxt_res = opnd_ff;
    endcase
  end

  wire res_zero = (res_ff == ZERO_BYTE);
  wire active = (op_ff != DCE_OP_NONE);
  wire to_acc = active && (dest_ff == DEST_ACC); // RULE_03
  wire to_reg = active && (dest_ff == DEST_REG); // RULE_09
  wire flag_upd = (op_ff == DCE_OP_INVERT) || (op_ff == DCE_OP_DEC); // RULE_10
  wire do_skip = (op_ff == DCE_OP_DEC_SKIP) && res_zero; // RULE_06

  dce_wr_t nxt_wr;
  assign nxt_wr.addr = addr_ff;
  assign nxt_wr.data = res_ff;
  assign nxt_wr.we = ph_four && to_reg;

  // ==========================================================
  // Decode latch and operand read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_ff <= DCE_OP_NONE;
      dest_ff <= DEST_ACC;
      addr_ff <= 7'h00;
    end else if (clk_en && ph_one) begin
      op_ff <= nxt_op; // RULE_04
      dest_ff <= dest_in; // RULE_01
      addr_ff <= addr_in & ADDR_MAX; // RULE_01
    end
  end

  // Register read on phase two, process on phase three
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      opnd_ff <= ZERO_BYTE;
      res_ff <= ZERO_BYTE;
    end else if (clk_en) begin
      if (ph_two) begin
        opnd_ff <= rd_data; // RULE_04
      end
      if (ph_three) begin
        res_ff <= nxt_res; // RULE_04
      end
    end
  end

  // ==========================================================
  // Write-back on phase four
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= ACC_RESET;
      zf_ff <= ZFLAG_RESET;
      idle_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else if (clk_en && ph_four) begin
      if (to_acc) begin
        acc_ff <= res_ff; // RULE_03
      end
      if (flag_upd) begin
        zf_ff <= res_zero; // RULE_10
      end
      idle_ff <= do_skip; // RULE_07
      skip_ff <= do_skip; // RULE_06
    end
  end

  // Port registers; write strobe holds one clock after phase four
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff <= '0;
      rd_en_ff <= 1'b0;
      rd_addr_ff <= 7'h00;
      busy_ff <= 1'b0;
      phase_ff <= 4'h0;
    end else if (clk_en) begin
      wr_ff <= nxt_wr; // RULE_09
      rd_en_ff <= ph_one && (nxt_op != DCE_OP_NONE);
      rd_addr_ff <= addr_in & ADDR_MAX;
      busy_ff <= active || idle_ff; // RULE_05
      phase_ff <= ph;
    end
  end

  assign acc = acc_ff;
  assign zero_flag = zf_ff;
  assign skip_next = skip_ff;
  assign reg_wr = wr_ff;
  assign rd_en = rd_en_ff;
  assign rd_addr = rd_addr_ff;
  assign busy = busy_ff;
  assign phase = phase_ff;

endmodule : dce_exec

// ==== verification/dce_exec_assertions.sv ====
// Checker: timing relations at the executor's ports
`timescale 1ns/1ps
module dce_exec_chk
  import dce_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire dce_instr_t instr_in,
  input wire logic [7:0] rd_data,
  input wire logic [6:0] rd_addr,
  input wire logic rd_en,
  input wire dce_wr_t reg_wr,
  input wire logic [7:0] acc,
  input wire logic zero_flag,
  input wire logic skip_next,
  input wire logic busy,
  input wire logic [3:0] phase
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ==========
  // Assertions and covers
  a_rd_phase: assert property (rd_en |-> phase == 4'h1)
    else $error("read strobe off phase");
  a_rd_addr: assert property (rd_en |-> $past(instr_in.valid)
    && rd_addr == $past(instr_in.word[6:0])) else $error("bad read addr");
  a_we_phase: assert property (reg_wr.we |-> phase == 4'h8)
    else $error("write off phase");
  a_we_addr: assert property (reg_wr.we |-> $past(rd_en, 3)
    && reg_wr.addr == $past(rd_addr, 3)) else $error("bad write addr");
  a_acc_when: assert property ($changed(acc) |-> phase == 4'h8)
    else $error("acc changed off phase");
  a_zf_when: assert property ($changed(zero_flag) |-> phase == 4'h8)
    else $error("flag changed off phase");
  a_skip_len: assert property ($rose(skip_next) |->
    skip_next[*4] ##1 !skip_next) else $error("skip length");
  a_skip_busy: assert property (skip_next |-> busy)
    else $error("idle cycle not busy");
  c_skip: cover property ($rose(skip_next));
  c_we: cover property (reg_wr.we);
  c_zf: cover property ($rose(zero_flag));
endmodule : dce_exec_chk
bind dce_exec dce_exec_chk u_dce_exec_chk(.clk_sys, .arst_n, .clk_en,
  .instr_in, .rd_data, .rd_addr, .rd_en, .reg_wr, .acc, .zero_flag,
  .skip_next, .busy, .phase);

// ==== verification/dce_rf.sv ====
// Partner model: register file serving the executor
`timescale 1ns/1ps
module dce_rf
  import dce_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [6:0] rd_addr,
  input wire logic rd_en,
  input wire dce_wr_t reg_wr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [128];
  // Inverse when unread, so stale data never passes
  assign rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];
  always @(posedge clk_sys) if (reg_wr.we) mem[reg_wr.addr] <= reg_wr.data;
endmodule : dce_rf

// ==== verification/tb_top.sv ====
// Testbench: scenarios for the decrement/complement executor
`timescale 1ns/1ps
module tb_top;
  import dce_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  dce_instr_t instr_in = '0;
  logic [7:0] rd_data, acc;
  logic [6:0] rd_addr;
  logic rd_en, zero_flag, skip_next, busy;
  dce_wr_t reg_wr;
  logic [3:0] phase;
  logic clk_en = 1'b1;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  dce_exec u_dce_exec(.clk_sys, .arst_n, .clk_en, .instr_in,
    .rd_data, .rd_addr, .rd_en, .reg_wr, .acc, .zero_flag, .skip_next,
    .busy, .phase);
  dce_rf u_dce_rf(.clk_sys, .rd_addr, .rd_en, .reg_wr, .rd_data);
  // ==========
  // Helpers
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  // Aligns so the request stands at the decode edge
  task go(input logic [5:0] op, input logic d, input logic [6:0] f);
    do @(posedge clk_sys) #1; while (phase !== 4'h4);
    @(posedge clk_sys) instr_in <= {op, d, f, 1'b1};
    @(posedge clk_sys) instr_in.valid <= 1'b0;
  endtask : go
  task fin;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : fin
  // ==========
  // Scenarios
  task t_dec;
    u_dce_rf.mem[5] = 8'h13;
    u_dce_rf.mem[127] = 8'h01;
    go(OPC_DEC, DEST_ACC, 7'h05);
    fin;
    chk(acc, 8'h12);
    chk(u_dce_rf.mem[5], 8'h13);
    chk(zero_flag, 8'h00);
    go(OPC_DEC, DEST_REG, ADDR_MAX);
    fin;
    chk(u_dce_rf.mem[127], 8'h00);
    chk(zero_flag, 8'h01);
  endtask : t_dec
  task t_inv;
    u_dce_rf.mem[0] = 8'h13;
    u_dce_rf.mem[1] = 8'hff;
    go(OPC_INVERT, DEST_ACC, 7'h00);
    fin;
    chk(acc, 8'hec);
    chk(zero_flag, 8'h00);
    go(OPC_INVERT, DEST_REG, 7'h01);
    fin;
    chk(u_dce_rf.mem[1], 8'h00);
    chk(zero_flag, 8'h01);
  endtask : t_inv
  task t_skip;
    u_dce_rf.mem[9] = 8'h03;
    u_dce_rf.mem[2] = 8'h01;
    u_dce_rf.mem[3] = 8'h44;
    go(OPC_DEC_SKIP, DEST_REG, 7'h09);
    fin;
    chk(u_dce_rf.mem[9], 8'h02);
    chk(skip_next, 8'h00);
    chk(zero_flag, 8'h01);
    go(OPC_DEC_SKIP, DEST_ACC, 7'h02);
    repeat (2) @(posedge clk_sys);
    @(posedge clk_sys) instr_in <= {OPC_DEC, DEST_REG, 7'h03, 1'b1};
    @(posedge clk_sys) instr_in.valid <= 1'b0;
    #1;
    chk(skip_next, 8'h01);
    chk(busy, 8'h01);
    fin;
    chk(acc, 8'h00);
    chk(u_dce_rf.mem[3], 8'h44);
    chk(zero_flag, 8'h01);
  endtask : t_skip
  // Enable low mid-instruction must freeze phase and write-back
  task t_hold;
    u_dce_rf.mem[6] = 8'h80;
    go(OPC_DEC, DEST_ACC, 7'h06);
    repeat (2) @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk(acc, 8'h00);
    chk(phase, 8'h04);
    @(posedge clk_sys) clk_en <= 1'b1;
    fin;
    chk(acc, 8'h7f);
    chk(zero_flag, 8'h00);
  endtask : t_hold
  // ==========
  // Run control
  task complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 1000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_dec;
    t_inv;
    t_skip;
    t_hold;
    complete_run;
  end
endmodule : tb_top
